// ### sim/buw_cfg_bank_bench.sv
// bench for the configuration bank: registers, control, window, arbiter
module buw_cfg_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import buw_pkg::*;
	logic i_sys_clk;
	logic i_rst_n;
	buw_cfg_req_t cq;
	logic [31:0] rdata;
	logic ack;
	logic [9:0] req;
	logic [9:0] start;
	logic [8:0] gnt;
	logic bgnt;
	logic vld;
	logic [63:0] sa;
	logic hit;
	logic fv;
	logic fwd;
	buw_ctrl_t ctrl;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] sh [8];
	logic [31:0] d;
	logic [7:0] ad;
	logic [63:0] lo;
	logic [63:0] hi;

	// ****************************************************************
	// design and secondary masters
	// ****************************************************************
	buw_cfg_bank #(.N_SEC_REQ(9)) dut (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_cfg(cq), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
		.i_sec_req(req[8:0]), .i_bridge_req(req[9]), .o_sec_gnt(gnt),
		.o_bridge_gnt(bgnt), .i_sec_addr_vld(vld), .i_sec_addr(sa),
		.i_down_win_hit(hit), .o_up_fwd_vld(fv), .o_up_fwd(fwd),
		.o_ctrl(ctrl));
	buw_sec_masters #(.HOLD(3)) u_masters (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_start(start), .i_gnt({bgnt, gnt}),
		.o_req(req));

	// free-running clock
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			complete_run();
		end
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// writable bits per dword from 40h upward; holes and reserved stay 0
	function logic [31:0] wmask(input logic [2:0] i);
		case (i)
			3'd0: return 32'h03FF_0000;
			3'd2: return 32'h0001_000F;
			3'd4: return 32'hFFF0_FFF0;
			3'd5, 3'd6: return 32'hFFFF_FFFF;
			default: return 32'h0000_0000;
		endcase
	endfunction : wmask

	function logic exp_fwd(input logic [63:0] x, input logic h);
		return sh[2][16] ? (x >= lo && x <= hi) : ~h;
	endfunction : exp_fwd

	// one access; a read is compared with the shadow before any write
	task cfg(input logic w, input logic r, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] dat);
		logic [2:0] i;
		logic [31:0] m;
		i = 3'((a - 8'h40) >> 2);
		m = wmask(i) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		@(posedge i_sys_clk);
		#1 cq = '{w, r, a, be, dat};
		@(posedge i_sys_clk);
		#1 cq = '0;
		chk({31'h0, ack}, 32'h1);
		if (r) chk(rdata, sh[i]);
		if (w) sh[i] = (sh[i] & ~m) | (dat & m);
	endtask : cfg

	task win(input logic [63:0] x);
		logic h;
		h = 1'($urandom % 2);
		@(posedge i_sys_clk);
		#1 vld = 1'b1;
		sa = x;
		hit = h;
		@(posedge i_sys_clk);
		#1 vld = 1'b0;
		chk({30'h0, fv, fwd}, {30'h0, 1'b1, exp_fwd(x, h)});
	endtask : win

	task gnt_wait(input logic [8:0] m);
		repeat (20) if (!(|(gnt & m))) @(posedge i_sys_clk);
		#1;
	endtask : gnt_wait

	task complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		i_rst_n = 1'b0;
		cq = '0;
		start = '0;
		vld = 1'b0;
		sa = '0;
		hit = 1'b0;
		sh = '{32'h0200_0000, 0, 0, 0, 32'h0001_0001, 0, 0, 0};
		void'($urandom(93));
		repeat (4) @(posedge i_sys_clk);
		#1 i_rst_n = 1'b1;
		for (int i = 0; i < 8; i++) cfg(0, 1, 8'(64 + i * 4), 4'hF, 0);
		for (int i = 0; i < 8; i++) begin
			cfg(1, 0, 8'(64 + i * 4), 4'hF, 32'hFFFF_FFFF);
			cfg(0, 1, 8'(64 + i * 4), 4'hF, 0);
		end
		repeat (60) begin
			d = $urandom;
			ad = 8'(64 + ($urandom % 8) * 4);
			cfg(1, 1'($urandom), ad, 4'($urandom), d);
			cfg(0, 1, ad, 4'hF, 0);
		end
		for (int v = 0; v < 32; v++) begin
			d = {15'h0, 1'(v >> 4), 12'h0, 4'(v)};
			cfg(1, 0, OFS_EXT_CTRL, 4'h5, d);
			@(posedge i_sys_clk);
			#1 chk({27'h0, ctrl}, {27'h0, d[0], d[1], ~d[2], ~d[3], d[16]});
		end
		repeat (6) begin
			d = $urandom;
			lo[11:0] = 12'($urandom % 2048);
			cfg(1, 0, OFS_UP_LOW, 4'hF,
				{lo[11:0] + 12'($urandom % 1000), 4'h0, lo[11:0], 4'h0});
			cfg(1, 0, OFS_UP_BASE_HI, 4'hF, d);
			cfg(1, 0, OFS_UP_LIMIT_HI, 4'hF, d);
			cfg(1, 0, OFS_EXT_CTRL, 4'h4, {15'h0, 1'($urandom), 16'h0});
			lo = {sh[5], sh[4][15:4], 20'h0_0000};
			hi = {sh[6], sh[4][31:20], 20'hF_FFFF};
			win(lo);
			win(lo - 1);
			win(hi);
			win(hi + 1);
			win({d, 32'($urandom)});
		end
		cfg(1, 0, OFS_ARB_PRIO, 4'hC, 32'h0020_0000);
		cfg(1, 0, OFS_EXT_CTRL, 4'hF, 0);
		start = 10'h028;
		@(posedge i_sys_clk);
		#1 start = '0;
		gnt_wait(9'h1FF);
		chk({23'h0, gnt}, 32'h20);
		gnt_wait(9'h008);
		chk({23'h0, gnt}, 32'h8);
		repeat (8) @(posedge i_sys_clk);
		#1 chk({22'h0, bgnt, gnt}, 32'h8);
		cfg(1, 0, OFS_EXT_CTRL, 4'h1, 32'h2);
		repeat (3) @(posedge i_sys_clk);
		#1 chk({22'h0, bgnt, gnt}, 32'h200);
		// bridge in the high group asks with a low master; it keeps the bus
		cfg(1, 0, OFS_ARB_PRIO, 4'h8, 32'h0200_0000);
		start = 10'h208;
		@(posedge i_sys_clk);
		#1 start = '0;
		@(posedge i_sys_clk);
		#1 chk({22'h0, bgnt, gnt}, 32'h200);
		gnt_wait(9'h008);
		chk({22'h0, bgnt, gnt}, 32'h8);
		complete_run();
	end
endmodule : buw_cfg_bank_bench

// ### sim/buw_cfg_bank_properties.sv
// port assertions for the configuration bank
module buw_cfg_bank_properties #(
	parameter int N_SEC_REQ = 9
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire buw_pkg::buw_cfg_req_t i_cfg,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic o_cfg_ack,
	input wire logic [N_SEC_REQ-1:0] i_sec_req,
	input wire logic i_bridge_req,
	input wire logic [N_SEC_REQ-1:0] o_sec_gnt,
	input wire logic o_bridge_gnt,
	input wire logic i_sec_addr_vld,
	input wire logic i_down_win_hit,
	input wire logic o_up_fwd_vld,
	input wire logic o_up_fwd,
	input wire buw_pkg::buw_ctrl_t o_ctrl
);
	import buw_pkg::*;

	// ****************************************************************
	// one clock domain only
	// ****************************************************************
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_ack_after_access: assert property ((i_cfg.rd || i_cfg.wr) |=> o_cfg_ack)
		else $error("access not acknowledged");
	a_arb_rsvd_zero: assert property (
		o_cfg_ack && $past(i_cfg.addr) == OFS_ARB_PRIO
		|-> o_cfg_rdata[31:26] == 6'h0 && o_cfg_rdata[15:0] == 16'h0)
		else $error("priority reserved bits set");
	a_ext_rsvd_zero: assert property (
		o_cfg_ack && $past(i_cfg.addr) == OFS_EXT_CTRL
		|-> o_cfg_rdata[31:17] == 15'h0 && o_cfg_rdata[15:4] == 12'h0)
		else $error("control reserved bits set");
	a_cap_reads_one: assert property (
		o_cfg_ack && $past(i_cfg.rd) && $past(i_cfg.addr) == OFS_UP_LOW
		|-> o_cfg_rdata[3:0] == CAP_64BIT && o_cfg_rdata[19:16] == CAP_64BIT)
		else $error("capability nibble wrong");
	// settings reach o_ctrl two edges after the write is taken
	a_flow_ctrl_lag: assert property (
		i_cfg.wr && i_cfg.addr == OFS_EXT_CTRL && i_cfg.be[0] |=> ##1
		o_ctrl.flow_through_en == $past(i_cfg.wdata[0], 2))
		else $error("flow-through setting lost");
	a_dyn_ctrl_lag: assert property (
		i_cfg.wr && i_cfg.addr == OFS_EXT_CTRL && i_cfg.be[0] |=> ##1
		o_ctrl.primary_toward_secondary_dyn_en != $past(i_cfg.wdata[2], 2)
		&& o_ctrl.secondary_toward_primary_dyn_en != $past(i_cfg.wdata[3], 2))
		else $error("prefetch control polarity wrong");
	a_fwd_vld_lag: assert property (
		o_up_fwd_vld == $past(i_sec_addr_vld) && (o_up_fwd_vld || !o_up_fwd))
		else $error("forward verdict timing wrong");
	// with the window off everything outside the downstream window goes up
	a_fwd_window_off: assert property (
		i_sec_addr_vld && !o_ctrl.up_window_en && !$past(i_cfg.wr)
		|=> o_up_fwd == !$past(i_down_win_hit))
		else $error("forward verdict wrong with window off");
	a_gnt_one_hot: assert property ($onehot0({o_bridge_gnt, o_sec_gnt}))
		else $error("more than one grant");
	a_park_bridge: assert property (
		(!(|i_sec_req) && !i_bridge_req && o_ctrl.park_on_bridge)[*2]
		|-> o_bridge_gnt)
		else $error("idle bus not parked on bridge");
endmodule : buw_cfg_bank_properties

bind buw_cfg_bank buw_cfg_bank_properties #(.N_SEC_REQ(N_SEC_REQ)) u_prop (
	.i_sys_clk, .i_rst_n, .i_cfg, .o_cfg_rdata, .o_cfg_ack, .i_sec_req,
	.i_bridge_req, .o_sec_gnt, .o_bridge_gnt, .i_sec_addr_vld,
	.i_down_win_hit, .o_up_fwd_vld, .o_up_fwd, .o_ctrl);

// ### sim/buw_sec_masters.sv
// behavioural secondary bus masters that request, hold and release the bus
module buw_sec_masters #(
	parameter int HOLD = 3
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [9:0] i_start,
	input wire logic [9:0] i_gnt,
	output logic [9:0] o_req
);
	int cnt [10];

	// ****************************************************************
	// request state per master, index 9 is the bridge's own master
	// ****************************************************************
	// a master keeps requesting while it owns the bus, so a slow HOLD
	// shows whether the arbiter really lets the owner keep its grant
	always @(posedge i_sys_clk) begin
		for (int i = 0; i < 10; i++) begin
			if (!i_rst_n) begin
				o_req[i] <= 1'b0;
				cnt[i] <= 0;
			end else if (i_start[i]) begin
				o_req[i] <= 1'b1;
			end else if (o_req[i] && i_gnt[i]) begin
				cnt[i] <= cnt[i] + 1;
				if (cnt[i] == HOLD - 1) begin
					o_req[i] <= 1'b0;
					cnt[i] <= 0;
				end
			end
		end
	end
endmodule : buw_sec_masters

// ### src/buw_cfg_bank.sv
// configuration bank: arbiter priority, transfer control, upstream window
//
// Functional notes
// (R1) bits 24:16 put each secondary request 8..0 in the high group when one.
// (R2) bit 25 puts the bridge's own secondary master in the high group.
// (R3) reserved bits read zero, ignore writes and reset to zero.
// (R4) extended control bit 0 enables memory read flow-through.
// (R5) bit 1 parks an idle bus on the bridge when one, last owner when zero.
// (R6) bit 2 clear enables dynamic prefetch toward the secondary side.
// (R7) bit 3 clear enables dynamic prefetch toward the primary side.
// (R8) bit 16 set confines upstream forwarding to the base/limit window.
// (R9) the capability nibbles of base and limit both read as one.
// (R10) base bits 15:4 hold the window lower bound address bits 31:20.
// (R11) limit bits 31:20 hold the window upper bound address bits 31:20.
// (R12) a 32-bit register holds lower bound address bits 63:32.
// (R13) a 32-bit register holds upper bound address bits 63:32.
// (R14) base low bits are zeros, limit low bits ones, bounds inclusive.
// (R15) high group requests win over low, rotating within each group.
module buw_cfg_bank #(
	parameter int N_SEC_REQ = 9
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire buw_pkg::buw_cfg_req_t i_cfg,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_ack,
	input wire logic [N_SEC_REQ-1:0] i_sec_req,
	input wire logic i_bridge_req,
	output logic [N_SEC_REQ-1:0] o_sec_gnt,
	output logic o_bridge_gnt,
	input wire logic i_sec_addr_vld,
	input wire logic [63:0] i_sec_addr,
	input wire logic i_down_win_hit,
	output logic o_up_fwd_vld,
	output logic o_up_fwd,
	output buw_pkg::buw_ctrl_t o_ctrl
);
	import buw_pkg::*;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	generate
		if (N_SEC_REQ != NUM_SEC_REQ) begin : g_bad_req
			$error("buw_cfg_bank: priority field is nine bits wide");
		end
	endgenerate

	// ****************************************************************
	// helpers
	// ****************************************************************

	// merge write data into an old dword under the byte enables
	function automatic logic [31:0] be_merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return res;
	endfunction : be_merge

	// inclusive range check on 64-bit addresses
	function automatic logic in_range(
		input logic [63:0] addr,
		input logic [63:0] lo,
		input logic [63:0] hi
	);
		return (addr >= lo) && (addr <= hi);
	endfunction : in_range

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [8:0] req_prio_r;
	logic [8:0] req_prio_nxt;
	logic bridge_prio_r;
	logic bridge_prio_nxt;
	logic [3:0] ext_ctrl_r;
	logic [3:0] ext_ctrl_nxt;
	logic up_win_en_r;
	logic up_win_en_nxt;
	logic [11:0] base_addr_r;
	logic [11:0] base_addr_nxt;
	logic [11:0] limit_addr_r;
	logic [11:0] limit_addr_nxt;
	logic [31:0] base_hi_r;
	logic [31:0] base_hi_nxt;
	logic [31:0] limit_hi_r;
	logic [31:0] limit_hi_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ack_r;
	logic fwd_vld_r;
	logic fwd_r;
	logic fwd_nxt;
	buw_ctrl_t ctrl_r;
	buw_ctrl_t ctrl_nxt;

	// ****************************************************************
	// address decode
	// ****************************************************************
	wire logic sel_prio = (i_cfg.addr == OFS_ARB_PRIO);
	wire logic sel_ext = (i_cfg.addr == OFS_EXT_CTRL);
	wire logic sel_low = (i_cfg.addr == OFS_UP_LOW);
	wire logic sel_bhi = (i_cfg.addr == OFS_UP_BASE_HI);
	wire logic sel_lhi = (i_cfg.addr == OFS_UP_LIMIT_HI);

	// ****************************************************************
	// read views of each dword
	// ****************************************************************

	// low half of 40h belongs to another register; reads zero here and
	// drops writes, so software may write the whole dword without harm
	wire logic [31:0] view_prio = {
		6'h00, // R3
		bridge_prio_r,
		req_prio_r,
		16'h0000
	};

	// bits 15:4 and 31:17 are reserved
	wire logic [31:0] view_ext = {
		15'h0000, // R3
		up_win_en_r,
		12'h000, // R3
		ext_ctrl_r
	};

	// base in the low half, limit in the high half
	wire logic [31:0] view_low = {
		limit_addr_r,
		CAP_64BIT, // R9
		base_addr_r,
		CAP_64BIT // R9
	};

	// merged images for writes; fixed and reserved bits fall away below
	wire logic [31:0] wr_prio = be_merge(view_prio, i_cfg.wdata, i_cfg.be);
	wire logic [31:0] wr_ext = be_merge(view_ext, i_cfg.wdata, i_cfg.be);
	wire logic [31:0] wr_low = be_merge(view_low, i_cfg.wdata, i_cfg.be);
	wire logic [31:0] wr_bhi = be_merge(base_hi_r, i_cfg.wdata, i_cfg.be);
	wire logic [31:0] wr_lhi = be_merge(limit_hi_r, i_cfg.wdata, i_cfg.be);

	wire logic do_prio = i_cfg.wr && sel_prio;
	wire logic do_ext = i_cfg.wr && sel_ext;
	wire logic do_low = i_cfg.wr && sel_low;
	wire logic do_bhi = i_cfg.wr && sel_bhi;
	wire logic do_lhi = i_cfg.wr && sel_lhi;

	// ****************************************************************
	// next values of the writable fields
	// ****************************************************************

	// only the defined bits are taken, so reserved writes vanish
	assign req_prio_nxt = do_prio ?
		wr_prio[POS_REQ_PRIO +: NUM_SEC_REQ] : req_prio_r; // R1
	assign bridge_prio_nxt = do_prio ?
		wr_prio[POS_BRIDGE_PRIO] : bridge_prio_r; // R2
	assign ext_ctrl_nxt = do_ext ?
		wr_ext[3:0] : ext_ctrl_r; // R4
	assign up_win_en_nxt = do_ext ?
		wr_ext[POS_UP_WIN_EN] : up_win_en_r; // R8
	assign base_addr_nxt = do_low ?
		wr_low[POS_BASE_ADDR +: WIN_ADDR_W] : base_addr_r; // R10
	assign limit_addr_nxt = do_low ?
		wr_low[POS_LIMIT_ADDR +: WIN_ADDR_W] : limit_addr_r; // R11
	assign base_hi_nxt = do_bhi ? wr_bhi : base_hi_r; // R12
	assign limit_hi_nxt = do_lhi ? wr_lhi : limit_hi_r; // R13

	// read mux; unmapped offsets read as zero
	// a read that comes with a write returns the contents before the write,
	// since the views are taken from the registers, not the merged images
	assign rdata_nxt = !i_cfg.rd ? READ_ZERO :
		sel_prio ? view_prio :
		sel_ext ? view_ext :
		sel_low ? view_low :
		sel_bhi ? base_hi_r :
		sel_lhi ? limit_hi_r : READ_ZERO;

	// ****************************************************************
	// register file
	// ****************************************************************

	// the limit stores only its address bits; they clear to zero while the
	// capability nibble beside them keeps reading one
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			req_prio_r <= RST_REQ_PRIO; // R1
			bridge_prio_r <= RST_BRIDGE_PRIO; // R2
			ext_ctrl_r <= RST_EXT_CTRL; // R4
			up_win_en_r <= RST_UP_WIN_EN; // R8
			base_addr_r <= RST_BASE_ADDR; // R10
			limit_addr_r <= RST_LIMIT_ADDR; // R11
			base_hi_r <= RST_HI_WORD; // R12
			limit_hi_r <= RST_HI_WORD; // R13
		end else begin
			req_prio_r <= req_prio_nxt;
			bridge_prio_r <= bridge_prio_nxt;
			ext_ctrl_r <= ext_ctrl_nxt;
			up_win_en_r <= up_win_en_nxt;
			base_addr_r <= base_addr_nxt;
			limit_addr_r <= limit_addr_nxt;
			base_hi_r <= base_hi_nxt;
			limit_hi_r <= limit_hi_nxt;
		end
	end

	// access answer: data and acknowledge one cycle after the request
	// every access is answered, mapped or not, so software never stalls
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rdata_r <= READ_ZERO;
			ack_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r <= i_cfg.rd || i_cfg.wr;
		end
	end

	// ****************************************************************
	// decoded controls for the prefetch and flow-through engines
	// ****************************************************************

	// prefetch bits are disable-when-one, so the engines get them inverted
	// the engines see a change one cycle after the register takes it
	assign ctrl_nxt.flow_through_en = ext_ctrl_r[POS_FLOW_EN]; // R4
	assign ctrl_nxt.park_on_bridge = ext_ctrl_r[POS_PARK]; // R5
	assign ctrl_nxt.primary_toward_secondary_dyn_en =
		~ext_ctrl_r[POS_P2S_DYN]; // R6
	assign ctrl_nxt.secondary_toward_primary_dyn_en =
		~ext_ctrl_r[POS_S2P_DYN]; // R7
	assign ctrl_nxt.up_window_en = up_win_en_r; // R8

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ****************************************************************
	// upstream window decode
	// ****************************************************************

	// 1 MB granularity: base pads with zeros, limit with ones
	// a limit below the base leaves the window empty, so nothing goes up
	// while the window is on; one wide compare is the longest path here
	wire logic [63:0] win_lo = {base_hi_r, base_addr_r, WIN_LOW_ZERO}; // R14
	wire logic [63:0] win_hi = {limit_hi_r, limit_addr_r, WIN_LOW_ONES}; // R14
	wire logic win_hit = in_range(i_sec_addr, win_lo, win_hi); // R14

	// disabled window means everything not claimed downstream goes up
	assign fwd_nxt = up_win_en_r ? win_hit : ~i_down_win_hit; // R8

	// registered once, so the verdict follows the address by one cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			fwd_vld_r <= 1'b0;
			fwd_r <= 1'b0;
		end else begin
			fwd_vld_r <= i_sec_addr_vld;
			fwd_r <= i_sec_addr_vld && fwd_nxt;
		end
	end

	// ****************************************************************
	// secondary arbitration
	// ****************************************************************
	logic [NUM_SEC_REQ:0] arb_gnt;

	// bridge sits above the external requests in the arbiter's view
	// there is no preemption: an owner that never lets go keeps the bus,
	// so a stuck master on the secondary side starves everyone else
	buw_sec_arbiter #(
		.N_REQ(NUM_SEC_REQ + 1)
	) u_arb (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_req({i_bridge_req, i_sec_req}),
		.i_high_group({bridge_prio_r, req_prio_r}), // R1 R2
		.i_park_on_bridge(ext_ctrl_r[POS_PARK]), // R5
		.o_gnt(arb_gnt)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign o_cfg_rdata = rdata_r;
	assign o_cfg_ack = ack_r;
	assign o_sec_gnt = arb_gnt[NUM_SEC_REQ-1:0];
	assign o_bridge_gnt = arb_gnt[NUM_SEC_REQ];
	assign o_up_fwd_vld = fwd_vld_r;
	assign o_up_fwd = fwd_r;
	assign o_ctrl = ctrl_r;

endmodule : buw_cfg_bank

// ### src/buw_pkg.sv
// package: offsets, field layouts, reset values and carrier types
package buw_pkg;

	// ****************************************************************
	// configuration offsets (byte addresses of aligned dwords)
	// ****************************************************************
	localparam logic [7:0] OFS_ARB_PRIO = 8'h40;
	localparam logic [7:0] OFS_EXT_CTRL = 8'h48;
	localparam logic [7:0] OFS_UP_LOW = 8'h50;
	localparam logic [7:0] OFS_UP_BASE_HI = 8'h54;
	localparam logic [7:0] OFS_UP_LIMIT_HI = 8'h58;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int NUM_SEC_REQ = 9;
	localparam int POS_REQ_PRIO = 16;
	localparam int POS_BRIDGE_PRIO = 25;
	localparam int POS_FLOW_EN = 0;
	localparam int POS_PARK = 1;
	localparam int POS_P2S_DYN = 2;
	localparam int POS_S2P_DYN = 3;
	localparam int POS_UP_WIN_EN = 16;
	localparam int POS_BASE_ADDR = 4;
	localparam int POS_LIMIT_CAP = 16;
	localparam int POS_LIMIT_ADDR = 20;
	localparam int WIN_ADDR_W = 12;
	localparam int WIN_GRAN_BITS = 20;

	// ****************************************************************
	// reset and fixed values
	// ****************************************************************
	localparam logic [8:0] RST_REQ_PRIO = 9'h000;
	localparam logic RST_BRIDGE_PRIO = 1'b1;
	localparam logic [3:0] RST_EXT_CTRL = 4'h0;
	localparam logic RST_UP_WIN_EN = 1'b0;
	localparam logic [11:0] RST_BASE_ADDR = 12'h000;
	localparam logic [11:0] RST_LIMIT_ADDR = 12'h000;
	localparam logic [31:0] RST_HI_WORD = 32'h0000_0000;
	localparam logic [3:0] CAP_64BIT = 4'h1;
	localparam logic [19:0] WIN_LOW_ZERO = 20'h0_0000;
	localparam logic [19:0] WIN_LOW_ONES = 20'hF_FFFF;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ****************************************************************
	// carrier for a configuration access
	// ****************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} buw_cfg_req_t;

	// decoded control settings handed to the datapath engines
	typedef struct packed {
		logic flow_through_en;
		logic park_on_bridge;
		logic primary_toward_secondary_dyn_en;
		logic secondary_toward_primary_dyn_en;
		logic up_window_en;
	} buw_ctrl_t;

endpackage : buw_pkg

// ### src/buw_sec_arbiter.sv
// secondary bus arbiter: two priority groups with rotation inside each
module buw_sec_arbiter #(
	parameter int N_REQ = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [N_REQ-1:0] i_req,
	input wire logic [N_REQ-1:0] i_high_group,
	input wire logic i_park_on_bridge,
	output logic [N_REQ-1:0] o_gnt
);
	import buw_pkg::*;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	generate
		if (N_REQ < 2 || N_REQ > 32) begin : g_bad_n
			$error("buw_sec_arbiter: N_REQ must be 2..32");
		end
	endgenerate

	// the bridge itself is the top index
	localparam logic [N_REQ-1:0] BRIDGE_ONEHOT = {1'b1, {(N_REQ-1){1'b0}}};

	// ****************************************************************
	// round robin pick: first request after the last winner
	// ****************************************************************
	function automatic logic [N_REQ-1:0] rr_pick(
		input logic [N_REQ-1:0] req,
		input logic [N_REQ-1:0] last
	);
		logic [N_REQ-1:0] pick;
		logic found;
		logic seen;
		pick = '0;
		found = 1'b0;
		seen = 1'b0;
		// pass one: entries above the last winner
		for (int i = 0; i < N_REQ; i++) begin
			if (seen && req[i] && !found) begin
				pick[i] = 1'b1;
				found = 1'b1;
			end
			if (last[i]) begin
				seen = 1'b1;
			end
		end
		// pass two: wrap round from the bottom
		for (int i = 0; i < N_REQ; i++) begin
			if (req[i] && !found) begin
				pick[i] = 1'b1;
				found = 1'b1;
			end
		end
		return pick;
	endfunction : rr_pick

	logic [N_REQ-1:0] gnt_r;
	logic [N_REQ-1:0] gnt_nxt;
	logic [N_REQ-1:0] last_hi_r;
	logic [N_REQ-1:0] last_lo_r;
	logic [N_REQ-1:0] last_r;

	// ****************************************************************
	// grant selection
	// ****************************************************************
	wire logic [N_REQ-1:0] req_hi = i_req & i_high_group;
	wire logic [N_REQ-1:0] req_lo = i_req & ~i_high_group;
	wire logic [N_REQ-1:0] pick_hi = rr_pick(req_hi, last_hi_r);
	wire logic [N_REQ-1:0] pick_lo = rr_pick(req_lo, last_lo_r);
	wire logic hold = |(gnt_r & i_req);

	// owner keeps the bus while it still asks; high group first (R15)
	always_comb begin
		if (hold) begin
			gnt_nxt = gnt_r;
		end else if (|req_hi) begin
			gnt_nxt = pick_hi; // R15
		end else if (|req_lo) begin
			gnt_nxt = pick_lo; // R15
		end else if (i_park_on_bridge) begin
			gnt_nxt = BRIDGE_ONEHOT; // R5
		end else begin
			gnt_nxt = last_r; // R5
		end
	end

	// grant and rotation pointers; parking starts on the bridge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			gnt_r <= BRIDGE_ONEHOT;
			last_r <= BRIDGE_ONEHOT;
			last_hi_r <= '0;
			last_lo_r <= '0;
		end else begin
			gnt_r <= gnt_nxt;
			if (|(gnt_nxt & i_req)) begin
				last_r <= gnt_nxt;
			end
			if (|(gnt_nxt & req_hi)) begin
				last_hi_r <= gnt_nxt;
			end
			if (|(gnt_nxt & req_lo)) begin
				last_lo_r <= gnt_nxt;
			end
		end
	end

	assign o_gnt = gnt_r;

endmodule : buw_sec_arbiter
